// >>> logic/ofc_pkg.sv
// shared constants and types for the overcurrent fault control block
// assumes a single 25 MHz clock domain
package ofc_pkg;
	localparam int NUM_CH = 3;
	localparam int CLK_MHZ = 25;
	// post-transition hold of boosted thresholds, in microseconds
	localparam int BOOST_HOLD_US = 50;
	localparam int BOOST_HOLD_CYC = BOOST_HOLD_US * CLK_MHZ;
	// one startup delay period, in microseconds
	localparam int STARTUP_DELAY_PERIOD_US = 1100;
	localparam int STARTUP_DELAY_PERIOD_CYC = STARTUP_DELAY_PERIOD_US * CLK_MHZ;
	localparam int RETRY_PERIODS = 8;
	localparam int RETRY_CYC = RETRY_PERIODS * STARTUP_DELAY_PERIOD_CYC;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

	// comparator results from the analog front end
	typedef struct packed {
		logic avg_over_norm;   // averaged current above normal reference
		logic avg_over_boost;  // averaged current above boosted reference
		logic monitor_over;    // current monitor pin above its threshold
		logic sense_ov;        // remote sense difference overvoltage
		logic [NUM_CH-1:0] ch_over_norm;  // per-channel above normal limit
		logic [NUM_CH-1:0] ch_over_boost; // per-channel above boosted limit
	} ofc_cmp_t;

	typedef struct packed {
		logic [NUM_CH-1:0] high_side_gate; // high-side gate permission
		logic [NUM_CH-1:0] low_side_force; // low-side gate forced on
		logic [NUM_CH-1:0] gate_off;       // both gates forced off
	} ofc_gate_t;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_RUN = 4'h2,
		ST_HICCUP = 4'h4,
		ST_LATCHED = 4'h8
	} ofc_state_t;
endpackage

// >>> logic/ofc_sync.sv
// two-flop synchroniser for one comparator bit
// assumes din is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ofc_sync (
	input wire logic sys_clk, // clock
	input wire logic reset, // async reset, active high
	input wire logic din, // asynchronous level
	output logic dout // synchronised level
);
	logic meta_r;
	logic meta_nxt;
	logic dout_nxt;

	always_comb begin
		meta_nxt = din;
		dout_nxt = meta_r;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			dout <= dout_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> logic/ofc_top.sv
// fault state machine, hiccup retry, threshold boost and channel limiting
// assumes comparator inputs are asynchronous; soft-start lives elsewhere
// Functional notes
// (R1) sense-line overvoltage stops regulation and latches off until enable toggle or reset
// (R2) averaged sense current over normal reference enters overcurrent shutdown
// (R3) transition start selects the boosted averaged-current threshold
// (R4) boost holds a fixed interval after transition end, then reverts
// (R5) current monitor above its voltage threshold enters overcurrent shutdown
// (R6) shutdown forces all gates off and drops regulator ready
// (R7) after shutdown wait eight startup delay periods, then retry soft-start
// (R8) shutdown and retry repeat until disabled or fault clears
// (R9) each channel current compared with its own limit independently
// (R10) over-limit channel: high side low, low side high at once
// (R11) limited high side stays low until current drops below limit
// (R12) channel limiting never shuts down the whole regulator
// (R13) per-channel limit boosted during transition plus fixed hold
// (R14) after overvoltage latch, restart only on enable toggle or reset
// (R15) all comparator results synchronised before the state machine
`timescale 1ns/1ps
`default_nettype none
module ofc_top import ofc_pkg::*; #(
	parameter int RETRY_CYCLES = RETRY_CYC, // shorten for simulation
	parameter int HOLD_CYCLES = BOOST_HOLD_CYC // shorten for simulation
) (
	input wire logic sys_clk, // 25 MHz clock
	input wire logic reset, // async reset, active high
	input wire logic enable, // regulator enable level
	input wire logic dyn_transition, // output-voltage transition active
	input wire logic softstart_done, // soft-start completed, level
	input wire ofc_cmp_t cmp_in, // asynchronous comparator results
	output ofc_gate_t gate_out, // gate overrides
	output logic regulator_ready_out, // ready, active high
	output logic softstart_start, // one-cycle pulse: begin soft-start
	output logic boost_active, // boosted thresholds selected
	output logic overcurrent_shutdown // in hiccup shutdown
);
	localparam int CMP_W = $bits(ofc_cmp_t);
	localparam logic [CNT_W-1:0] RETRY_LOAD = CNT_W'(RETRY_CYCLES);
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES);

	logic [CMP_W-1:0] cmp_raw;
	logic [CMP_W-1:0] cmp_bits;
	ofc_cmp_t cmp;

	assign cmp_raw = cmp_in;

	genvar gi;
	generate
		for (gi = 0; gi < CMP_W; gi++) begin : g_sync
			ofc_sync u_sync ( // [R15]
				.sys_clk(sys_clk),
				.reset(reset),
				.din(cmp_raw[gi]),
				.dout(cmp_bits[gi])
			);
		end
	endgenerate
	assign cmp = cmp_bits;

	ofc_state_t state_r, state_nxt;
	logic [CNT_W-1:0] retry_cnt_r, retry_cnt_nxt;
	logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
	logic boost_r, boost_nxt;
	logic enable_d_r, enable_d_nxt;
	logic avg_trip;
	logic ch_over_any;
	logic [NUM_CH-1:0] ch_over;
	ofc_gate_t gate_nxt;
	logic ready_nxt;
	logic ss_start_nxt;
	logic ocs_nxt;

	// boost follows the raw transition flag; hold timer starts at its end
	always_comb begin
		boost_nxt = boost_r;
		hold_cnt_nxt = hold_cnt_r;
		if (dyn_transition) begin
			boost_nxt = 1'b1; // [R3] [R13]
			hold_cnt_nxt = HOLD_LOAD;
		end else if (boost_r) begin
			if (hold_cnt_r <= CNT_ONE) begin
				boost_nxt = 1'b0; // [R4] [R13]
				hold_cnt_nxt = CNT_ZERO;
			end else begin
				hold_cnt_nxt = hold_cnt_r - CNT_ONE;
			end
		end
	end

	always_comb begin
		avg_trip = boost_r ? cmp.avg_over_boost : cmp.avg_over_norm; // [R2]
		ch_over = boost_r ? cmp.ch_over_boost : cmp.ch_over_norm; // [R9]
		ch_over_any = |ch_over;
	end

	always_comb begin
		state_nxt = state_r;
		retry_cnt_nxt = retry_cnt_r;
		enable_d_nxt = enable;
		ss_start_nxt = 1'b0;
		case (state_r)
			ST_OFF: begin
				retry_cnt_nxt = CNT_ZERO;
				if (enable) begin
					state_nxt = ST_RUN;
					ss_start_nxt = 1'b1;
				end
			end
			ST_RUN: begin
				if (!enable) begin
					state_nxt = ST_OFF;
				end else if (cmp.sense_ov) begin
					state_nxt = ST_LATCHED; // [R1]
				end else if (avg_trip || cmp.monitor_over) begin
					state_nxt = ST_HICCUP; // [R2] [R5]
					retry_cnt_nxt = RETRY_LOAD;
				end
			end
			ST_HICCUP: begin
				if (!enable) begin
					state_nxt = ST_OFF; // [R8]
				end else if (cmp.sense_ov) begin
					state_nxt = ST_LATCHED;
				end else if (retry_cnt_r <= CNT_ONE) begin
					state_nxt = ST_RUN; // [R7] [R8]
					ss_start_nxt = 1'b1;
					retry_cnt_nxt = CNT_ZERO;
				end else begin
					retry_cnt_nxt = retry_cnt_r - CNT_ONE;
				end
			end
			ST_LATCHED: begin
				// only a falling enable or reset clears the latch
				if (enable_d_r && !enable) begin
					state_nxt = ST_OFF; // [R14]
				end
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	always_comb begin
		ocs_nxt = (state_nxt == ST_HICCUP);
		ready_nxt = (state_nxt == ST_RUN) && softstart_done; // [R6]
		for (int i = 0; i < NUM_CH; i++) begin
			// channel limit stays local; it never moves the state machine
			gate_nxt.gate_off[i] = (state_nxt != ST_RUN); // [R6] [R12]
			gate_nxt.high_side_gate[i] = (state_nxt == ST_RUN) &&
				!ch_over[i]; // [R10] [R11]
			gate_nxt.low_side_force[i] = (state_nxt == ST_RUN) &&
				ch_over[i]; // [R10]
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_OFF;
			retry_cnt_r <= CNT_ZERO;
			hold_cnt_r <= CNT_ZERO;
			boost_r <= 1'b0;
			enable_d_r <= 1'b0;
			gate_out <= '0;
			regulator_ready_out <= 1'b0;
			softstart_start <= 1'b0;
			boost_active <= 1'b0;
			overcurrent_shutdown <= 1'b0;
		end else begin
			state_r <= state_nxt;
			retry_cnt_r <= retry_cnt_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			boost_r <= boost_nxt;
			enable_d_r <= enable_d_nxt;
			gate_out <= gate_nxt;
			regulator_ready_out <= ready_nxt;
			softstart_start <= ss_start_nxt;
			boost_active <= boost_nxt;
			overcurrent_shutdown <= ocs_nxt;
		end
	end

	sequence s_trip;
		state_r == ST_RUN && enable && !cmp.sense_ov &&
			(avg_trip || cmp.monitor_over);
	endsequence

	sequence s_off_gates;
		(&gate_out.gate_off) && !regulator_ready_out &&
			(gate_out.high_side_gate == '0);
	endsequence

	AST_OV_LATCH: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
		(state_r == ST_RUN && enable && cmp.sense_ov) |=>
			state_r == ST_LATCHED)
		else $error("overvoltage did not latch off");

	AST_TRIP_HICCUP: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
		s_trip |=> state_r == ST_HICCUP)
		else $error("overcurrent did not enter shutdown");

	AST_MON_TRIP: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
		(state_r == ST_RUN && enable && !cmp.sense_ov && cmp.monitor_over)
			|=> overcurrent_shutdown)
		else $error("monitor trip missed");

	AST_BOOST_START: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
		dyn_transition |=> boost_r && boost_active)
		else $error("boost not raised at transition");

	AST_BOOST_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
		$fell(dyn_transition) |-> boost_r)
		else $error("boost dropped at transition end");

	AST_SHUT_GATES: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
		s_trip |=> s_off_gates)
		else $error("gates not off in shutdown");

	AST_RETRY: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
		(state_r == ST_HICCUP && enable && !cmp.sense_ov &&
			retry_cnt_r == CNT_ONE) |=> softstart_start && state_r == ST_RUN)
		else $error("retry not started after delay");

	AST_CH_LIMIT: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
		(state_nxt == ST_RUN && ch_over[0]) |=>
			!gate_out.high_side_gate[0] && gate_out.low_side_force[0])
		else $error("channel limit not applied");

	AST_CH_LOCAL: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
		(state_r == ST_RUN && enable && ch_over_any && !avg_trip &&
			!cmp.monitor_over && !cmp.sense_ov) |=> state_r == ST_RUN)
		else $error("channel limit shut regulator");

	AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
		(state_r == ST_LATCHED && !(enable_d_r && !enable)) |=>
			state_r == ST_LATCHED)
		else $error("latch released without enable toggle");
endmodule
`default_nettype wire

// >>> bench/ofc_ss_model.sv
// soft-start partner: raises done a few cycles after each start pulse
// assumes the block marks a stopped regulator by its gate_off outputs
`timescale 1ns/1ps
`default_nettype none
module ofc_ss_model #(
	parameter int SS_CYC = 4
) (
	input wire logic sys_clk, // clock
	input wire logic reset, // async reset, active high
	input wire logic start, // soft-start request pulse
	input wire logic shut, // regulator stopped
	output logic done // ramp finished
);
	int cnt;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt <= 0;
			done <= 1'b0;
		end else if (start) begin
			cnt <= SS_CYC;
			done <= 1'b0;
		end else if (shut) begin
			// a stopped regulator loses its ramp at once
			cnt <= 0;
			done <= 1'b0;
		end else if (cnt == 1) begin
			cnt <= 0;
			done <= 1'b1;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// >>> bench/ofc_top_bench.sv
// self-checking bench for the fault control block
// assumes short retry and hold counts; outputs checked via a queue
`timescale 1ns/1ps
`default_nettype none
module ofc_top_bench;
	import ofc_pkg::*;
	localparam int RC = 20;
	localparam int HC = 5;
	localparam logic [11:0] RUNV = 12'h5c0;
	localparam logic [11:0] SHUT = 12'h807;
	localparam logic [11:0] LATV = 12'h007;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic enable = 1'b0;
	logic dyn = 1'b0;
	logic ss_done;
	ofc_cmp_t cmp = '0;
	ofc_gate_t gate_out;
	logic rdy, ss_start, boost, ocs;
	int miscompares = 0;
	int tests_run = 0;
	int pulses = 0;
	int cycles = 0;
	int ch, n;
	logic [11:0] q[$];
	event ev_chk;
	ofc_top #(.RETRY_CYCLES(RC), .HOLD_CYCLES(HC)) u_ofc_top (
		.sys_clk(sys_clk), .reset(reset), .enable(enable),
		.dyn_transition(dyn), .softstart_done(ss_done), .cmp_in(cmp),
		.gate_out(gate_out), .regulator_ready_out(rdy),
		.softstart_start(ss_start), .boost_active(boost),
		.overcurrent_shutdown(ocs));
	ofc_ss_model u_ofc_ss_model (.sys_clk(sys_clk), .reset(reset),
		.start(ss_start), .shut(|gate_out.gate_off), .done(ss_done));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic cyc(int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic expect_out(logic [11:0] e);
		q.push_back(e);
		-> ev_chk;
	endtask
	task automatic chk_cnt(int e);
		tests_run++;
		if (pulses != e) begin
			miscompares++;
			$display("MISMATCH %0t start pulses %0d", $time, pulses);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(ev_chk) begin : watch
		logic [11:0] e;
		logic [11:0] g;
		e = q.pop_front();
		g = {ocs, rdy, boost, gate_out};
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t outputs %h expected %h", $time, g, e);
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (ss_start === 1'b1) pulses++;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(32762));
		cyc(2);
		reset = 1'b0;
		enable = 1'b1;
		cyc(10);
		expect_out(RUNV);
		chk_cnt(1);
		ch = $urandom % 3;
		cmp.ch_over_norm[ch] = 1'b1;
		cyc(4);
		expect_out({3'b010, ~(3'h1 << ch), 3'h1 << ch, 3'h0});
		cmp.ch_over_norm = '0;
		cyc(4);
		expect_out(RUNV);
		cmp.avg_over_norm = 1'b1;
		cyc(1);
		expect_out(RUNV);
		cyc(3);
		expect_out(SHUT);
		cyc(RC - 6);
		chk_cnt(1);
		cyc(6);
		chk_cnt(2);
		expect_out(SHUT);
		cmp.avg_over_norm = 1'b0;
		cyc(RC + 12);
		expect_out(RUNV);
		cmp.monitor_over = 1'b1;
		cyc(4);
		expect_out(SHUT);
		cmp.monitor_over = 1'b0;
		cyc(RC + 12);
		dyn = 1'b1;
		cmp.avg_over_norm = 1'b1;
		cmp.ch_over_norm = 3'h7;
		cmp.ch_over_boost[ch] = 1'b1;
		cyc(6);
		expect_out({3'b011, ~(3'h1 << ch), 3'h1 << ch, 3'h0});
		dyn = 1'b0;
		cmp.avg_over_norm = 1'b0;
		cyc(HC - 2);
		expect_out({3'b011, ~(3'h1 << ch), 3'h1 << ch, 3'h0});
		cyc(8);
		expect_out(12'h438);
		cmp.ch_over_norm = '0;
		cmp.ch_over_boost = '0;
		cyc(4);
		// only the boosted comparator is raised, so a trip proves it is used
		dyn = 1'b1;
		cmp.avg_over_boost = 1'b1;
		cyc(4);
		expect_out(12'ha07);
		dyn = 1'b0;
		cmp.avg_over_boost = 1'b0;
		cyc(RC + 12);
		expect_out(RUNV);
		cmp.sense_ov = 1'b1;
		cyc(4);
		expect_out(LATV);
		cmp.sense_ov = 1'b0;
		n = pulses;
		cyc(RC + 10);
		expect_out(LATV);
		chk_cnt(n);
		enable = 1'b0;
		cyc(2);
		enable = 1'b1;
		cyc(10);
		expect_out(RUNV);
		chk_cnt(n + 1);
		cmp.sense_ov = 1'b1;
		cyc(4);
		expect_out(LATV);
		cmp.sense_ov = 1'b0;
		// let the watcher sample before reset clears the outputs
		cyc(1);
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(10);
		expect_out(RUNV);
		chk_cnt(n + 2);
		cyc(1);
		end_sim();
	end
endmodule
`default_nettype wire
